/* hdl/pin_mux_pkg.sv */
// Constants for the shared-pin function selector: pin indices, register
// offsets, field positions, reset values and select codes.
// Assumes one clock domain and a 32-bit Avalon-MM register port.
package pin_mux_pkg;
  // Register port widths.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // Byte offsets of the registers.
  localparam logic [ADDR_W-1:0] OFS_SYSTEM_SETUP = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_PINSEL   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PORT_C_VIEW  = 4'h8;

  // Reset values; all zero puts every shared pin on its primary function.
  localparam logic [REG_W-1:0] SYSTEM_SETUP_RST = 8'h00;
  localparam logic [REG_W-1:0] IRQ_PINSEL_RST   = 8'h00;

  // Field positions.
  localparam int SYS_HOST_BIT   = 1;
  localparam int SYS_CHAN2_BIT  = 2;
  localparam int SYS_PORT_C_BIT = 7;
  localparam int PS_DAISY_BIT   = 2;
  localparam int PS_STROBE_BIT  = 3;

  // Select codes: which of the three functions owns a pin.
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] SEL_PRI = 2'h0;
  localparam logic [SEL_W-1:0] SEL_SEC = 2'h1;
  localparam logic [SEL_W-1:0] SEL_TER = 2'h2;

  // Level seen by a function whose pin is taken by another one.
  localparam logic IDLE_IN = 1'b1;

  // Pin indices.
  localparam int NUM_PINS   = 28;
  localparam int PIN_TRI0   = 0;   // Serial tx / chan2 ready-req / host irq.
  localparam int PIN_TRI2   = 2;   // Last of the three triple-function pins.
  localparam int PIN_PA0    = 3;   // Eight port A / host data pins.
  localparam int PIN_PA7    = 10;
  localparam int PIN_CH2_0  = 11;  // Seven chan2 / host strobe-address pins.
  localparam int PIN_CH2_6  = 17;
  localparam int PIN_CHAN1_WAIT_REQ = 18;  // Port C bit 5.
  localparam int PIN_DTR_A  = 19;  // Port C bit 3.
  localparam int PIN_MWR    = 20;  // Port C bit 2 or chan1 request-to-send.
  localparam int PIN_CTS_A  = 21;  // Port C bit 1.
  localparam int PIN_DCD_A  = 22;  // Port C bit 0.
  localparam int PIN_SYNC_A = 23;  // Port C bit 4.
  localparam int PIN_DAISY  = 24;
  localparam int PIN_MSTRB  = 25;
  localparam int PIN_IRQ1   = 26;  // Port C bit 6, input only.
  localparam int PIN_IRQ2   = 27;  // Port C bit 7, input only.
endpackage : pin_mux_pkg

/* hdl/pin_route_cell.sv */
// One shared pin: picks the owning function's drive and enable, and hands
// the pad level to the owner. All outputs are registered.
// Assumes sel only ever holds a primary, secondary or tertiary code.
`timescale 1ns/10ps
`default_nettype none
module pin_route_cell
  import pin_mux_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [SEL_W-1:0]       sel,
  input  wire logic                   force_oe,
  input  wire logic                   force_oe_val,
  input  wire logic                   share_in,
  input  wire logic [2:0]             fn_out,
  input  wire logic [2:0]             fn_oe,
  input  wire logic                   pad_in,
  output logic                        pad_out,
  output logic                        pad_oe,
  output logic [2:0]                  fn_in
);
  logic       out_q, out_d;
  logic       oe_q, oe_d;
  logic [2:0] in_q, in_d;

  // Route the owner; idle functions see a quiet high level, which keeps
  // active-low inputs of parked units inactive.
  always_comb begin
    case (sel)
      SEL_SEC: begin
        out_d = fn_out[1];
        oe_d  = fn_oe[1];
      end
      SEL_TER: begin
        out_d = fn_out[2];
        oe_d  = fn_oe[2];
      end
      default: begin
        out_d = fn_out[0];
        oe_d  = fn_oe[0];
      end
    endcase
    if (force_oe) begin
      oe_d = force_oe_val;
    end
    for (int k = 0; k < 3; k++) begin
      in_d[k] = (share_in || (sel == SEL_W'(k))) ? pad_in : IDLE_IN;
    end
  end

  // The pad starts undriven so nothing fights the board during reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= 1'b1;
      oe_q  <= 1'b0;
      in_q  <= 3'h7;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      in_q  <= in_d;
    end
  end

  assign pad_out = out_q;
  assign pad_oe  = oe_q;
  assign fn_in   = in_q;
endmodule : pin_route_cell
`default_nettype wire

/* hdl/pin_function_selector.sv */
// Shared-pin function selector with its two mux control registers and a
// read-only view of port C, reached over an Avalon-MM slave.
// Assumes on-chip units present drive, enable and input per function per
// pin, and that the pad logic resolves pad_out/pad_oe into the wire.
//
// Contract
// [RL1] Host mode bit moves port A and chan2
// [RL2] Bits 1,2 pick among three functions
// [RL3] Port C bit moves chan1 pins to port C
// [RL4] Write-strobe pin offers port C2, chan1 RTS
// [RL5] Daisy pin direction set by pinsel bit 2
// [RL6] Memory strobe kind set by pinsel bit 3
// [RL7] Port C 6,7 read interrupt pin levels
// [RL8] Port C bit one: port C, zero: serial
// [RL9] Pinsel bit 3 then port C bit choose
// [RL10] Unmuxed pins always keep primary function
// [RL11] Reset puts every pin on primary function
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pin_function_selector
  import pin_mux_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [pin_mux_pkg::DATA_W-1:0]   avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_in,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pad_out,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] fn1_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] fn1_oe,
  output logic [pin_mux_pkg::NUM_PINS-1:0] fn1_in,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] fn2_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] fn2_oe,
  output logic [pin_mux_pkg::NUM_PINS-1:0] fn2_in,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] fn3_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] fn3_oe,
  output logic [pin_mux_pkg::NUM_PINS-1:0] fn3_in
);
  import pin_mux_pkg::*;

  logic [REG_W-1:0]  sys_q, sys_d;
  logic [REG_W-1:0]  psel_q, psel_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              wait_q, wait_d;
  logic [REG_W-1:0]  port_c_view;
  logic [SEL_W-1:0]  sel_v [NUM_PINS];
  logic [2:0]        fin_v [NUM_PINS];

  // Owner of each pin as a function of the two control registers.
  function automatic logic [SEL_W-1:0] pin_select(input int idx,
                                                  input logic [REG_W-1:0] sys,
                                                  input logic [REG_W-1:0] ps);
    logic [SEL_W-1:0] s;
    s = SEL_PRI;                                             // RL10
    if (idx >= PIN_TRI0 && idx <= PIN_TRI2) begin
      if (sys[SYS_HOST_BIT]) begin
        s = SEL_TER;                                         // RL2
      end else if (sys[SYS_CHAN2_BIT]) begin
        s = SEL_SEC;                                         // RL2
      end
    end else if (idx >= PIN_PA0 && idx <= PIN_CH2_6) begin
      s = sys[SYS_HOST_BIT] ? SEL_SEC : SEL_PRI;             // RL1
    end else if (idx == PIN_MWR) begin
      if (ps[PS_STROBE_BIT]) begin                           // RL4
        s = sys[SYS_PORT_C_BIT] ? SEL_SEC : SEL_TER;         // RL9
      end
    end else if (idx >= PIN_CHAN1_WAIT_REQ && idx <= PIN_SYNC_A) begin
      s = sys[SYS_PORT_C_BIT] ? SEL_SEC : SEL_PRI;           // RL3 RL8
    end else if (idx == PIN_DAISY) begin
      s = ps[PS_DAISY_BIT] ? SEL_SEC : SEL_PRI;              // RL5
    end else if (idx == PIN_MSTRB) begin
      s = ps[PS_STROBE_BIT] ? SEL_SEC : SEL_PRI;             // RL6
    end
    return s;
  endfunction : pin_select

  // Selects are decoded straight from the stored bits, so a write shows
  // at the pins one clock after the register changes.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      sel_v[i] = pin_select(i, sys_q, psel_q);
    end
  end

  // One routing cell per pin. The daisy pin's direction belongs to the
  // selector, not to the units; interrupt pins share their level with port C.
  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      pin_route_cell u_cell (
        .clk          (clk),
        .rst          (rst),
        .sel          (sel_v[g]),
        .force_oe     (g == PIN_DAISY),
        .force_oe_val (sel_v[g] == SEL_SEC),                 // RL5
        .share_in     (g == PIN_IRQ1 || g == PIN_IRQ2),      // RL7
        .fn_out       ({fn3_out[g], fn2_out[g], fn1_out[g]}),
        .fn_oe        ({fn3_oe[g], fn2_oe[g], fn1_oe[g]}),
        .pad_in       (pad_in[g]),
        .pad_out      (pad_out[g]),
        .pad_oe       (pad_oe[g]),
        .fn_in        (fin_v[g])
      );
      assign fn1_in[g] = fin_v[g][0];
      assign fn2_in[g] = fin_v[g][1];
      assign fn3_in[g] = fin_v[g][2];
    end
  endgenerate

  // Port C as software sees it; bits 6 and 7 always follow the interrupt pins.
  assign port_c_view = {fin_v[PIN_IRQ2][1], fin_v[PIN_IRQ1][1],   // RL7
                        fin_v[PIN_CHAN1_WAIT_REQ][1], fin_v[PIN_SYNC_A][1],
                        fin_v[PIN_DTR_A][1], fin_v[PIN_MWR][1],
                        fin_v[PIN_CTS_A][1], fin_v[PIN_DCD_A][1]};

  // Bus slave: every access waits exactly one cycle. The write lands and the
  // read data stand at the one edge where waitrequest is low.
  always_comb begin
    sys_d   = sys_q;
    psel_d  = psel_q;
    rdata_d = rdata_q;
    wait_d  = 1'b1;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d  = 1'b0;
      rdata_d = '0;
      if (avs_read) begin
        case (avs_address)
          OFS_SYSTEM_SETUP: rdata_d = {{(DATA_W-REG_W){1'b0}}, sys_q};
          OFS_IRQ_PINSEL:   rdata_d = {{(DATA_W-REG_W){1'b0}}, psel_q};
          OFS_PORT_C_VIEW:  rdata_d = {{(DATA_W-REG_W){1'b0}}, port_c_view};
          default:          rdata_d = '0;
        endcase
      end
    end
    if (avs_write && !wait_q && avs_byteenable[0]) begin
      case (avs_address)
        OFS_SYSTEM_SETUP: sys_d  = avs_writedata[REG_W-1:0];
        OFS_IRQ_PINSEL:   psel_d = avs_writedata[REG_W-1:0];
        default:          sys_d  = sys_q;
      endcase
    end
  end

  // Control registers clear to the all-primary pin map.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_q   <= SYSTEM_SETUP_RST;                           // RL11
      psel_q  <= IRQ_PINSEL_RST;                             // RL11
      rdata_q <= '0;
      wait_q  <= 1'b1;
    end else begin
      sys_q   <= sys_d;
      psel_q  <= psel_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // Checks. Helper flag marks the first cycle after reset release.
  logic first_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_host_data;
    sys_q[SYS_HOST_BIT] && $past(sys_q[SYS_HOST_BIT])
      |-> pad_out[PIN_PA0] == $past(fn2_out[PIN_PA0])
          && pad_oe[PIN_CH2_0] == $past(fn2_oe[PIN_CH2_0]);
  endproperty
  a_host_data: assert property (p_host_data) // RL1
    else $error("Host mode did not route port A or chan2 pins.");

  // The far end of both groups moves too, and the parked units read idle.
  property p_host_strobe;
    $past(sys_q[SYS_HOST_BIT])
      |-> pad_out[PIN_CH2_6] == $past(fn2_out[PIN_CH2_6])
          && pad_oe[PIN_PA7] == $past(fn2_oe[PIN_PA7])
          && fn1_in[PIN_PA7] == IDLE_IN;
  endproperty
  a_host_strobe: assert property (p_host_strobe) // RL1
    else $error("Host mode left a port A or chan2 pin behind.");

  // Host mode wins the triple pins even when the chan2 bit is also set.
  property p_triple_pick;
    $past(sys_q[SYS_HOST_BIT])
      |-> pad_out[PIN_TRI0] == $past(fn3_out[PIN_TRI0])
          && pad_oe[PIN_TRI2] == $past(fn3_oe[PIN_TRI2]);
  endproperty
  a_triple_pick: assert property (p_triple_pick) // RL2
    else $error("Triple pin not on host function.");

  property p_triple_sec;
    $past(!sys_q[SYS_HOST_BIT] && sys_q[SYS_CHAN2_BIT])
      |-> pad_oe[PIN_TRI2] == $past(fn2_oe[PIN_TRI2])
          && fn2_in[PIN_TRI0] == $past(pad_in[PIN_TRI0]);
  endproperty
  a_triple_sec: assert property (p_triple_sec) // RL2
    else $error("Triple pin not on chan2 function.");

  // With both bits clear the triple pins stay on the processor's signals.
  property p_triple_pri;
    !first_q && $past(!sys_q[SYS_HOST_BIT] && !sys_q[SYS_CHAN2_BIT])
      |-> pad_out[PIN_TRI2] == $past(fn1_out[PIN_TRI2])
          && fn3_in[PIN_TRI0] == IDLE_IN;
  endproperty
  a_triple_pri: assert property (p_triple_pri) // RL2
    else $error("Triple pin left its primary function.");

  property p_port_c_route;
    $past(sys_q[SYS_PORT_C_BIT]) |-> pad_out[PIN_CHAN1_WAIT_REQ] == $past(fn2_out[PIN_CHAN1_WAIT_REQ]);
  endproperty
  a_port_c_route: assert property (p_port_c_route) // RL3
    else $error("Chan1 pin not moved to port C.");

  // Port C owns drive and enable of every moved chan1 pin, not only the data.
  property p_port_c_all;
    $past(sys_q[SYS_PORT_C_BIT])
      |-> pad_oe[PIN_DCD_A] == $past(fn2_oe[PIN_DCD_A])
          && pad_out[PIN_SYNC_A] == $past(fn2_out[PIN_SYNC_A])
          && fn1_in[PIN_CTS_A] == IDLE_IN;
  endproperty
  a_port_c_all: assert property (p_port_c_all) // RL8
    else $error("Chan1 pin kept its serial function under port C mode.");

  property p_mwr_pick;
    $past(psel_q[PS_STROBE_BIT]) |->
      pad_out[PIN_MWR] == ($past(sys_q[SYS_PORT_C_BIT]) ? $past(fn2_out[PIN_MWR])
                                                        : $past(fn3_out[PIN_MWR]));
  endproperty
  a_mwr_pick: assert property (p_mwr_pick) // RL9
    else $error("Write-strobe pin alternative chosen wrongly.");

  // Skips the first edge after reset, where the pad still holds its reset level.
  property p_mwr_primary;
    !first_q && !$past(psel_q[PS_STROBE_BIT])
      |-> pad_out[PIN_MWR] == $past(fn1_out[PIN_MWR]);
  endproperty
  a_mwr_primary: assert property (p_mwr_primary) // RL4
    else $error("Write-strobe pin lost its strobe.");

  property p_daisy_dir;
    pad_oe[PIN_DAISY] == $past(psel_q[PS_DAISY_BIT]);
  endproperty
  a_daisy_dir: assert property (p_daisy_dir) // RL5
    else $error("Daisy pin direction disagrees with control bit.");

  // As an input the daisy pin feeds only the enable-in function.
  property p_daisy_in;
    !first_q && !$past(psel_q[PS_DAISY_BIT])
      |-> fn1_in[PIN_DAISY] == $past(pad_in[PIN_DAISY]) && fn2_in[PIN_DAISY] == IDLE_IN;
  endproperty
  a_daisy_in: assert property (p_daisy_in) // RL5
    else $error("Daisy pin input not given to enable-in.");

  property p_strobe_kind;
    $past(psel_q[PS_STROBE_BIT]) |-> pad_out[PIN_MSTRB] == $past(fn2_out[PIN_MSTRB]);
  endproperty
  a_strobe_kind: assert property (p_strobe_kind) // RL6
    else $error("Memory strobe pin not on request strobe.");

  // The interrupt pins have no alternative, whatever the control bits say.
  property p_unmuxed;
    !first_q |-> pad_out[PIN_IRQ2] == $past(fn1_out[PIN_IRQ2])
                 && pad_oe[PIN_IRQ2] == $past(fn1_oe[PIN_IRQ2]);
  endproperty
  a_unmuxed: assert property (p_unmuxed) // RL10
    else $error("Pin without alternatives left its primary function.");

  property p_irq_share;
    !first_q |-> fn2_in[PIN_IRQ1] == $past(pad_in[PIN_IRQ1])
                 && fn1_in[PIN_IRQ2] == $past(pad_in[PIN_IRQ2])
                 && pad_out[PIN_IRQ1] == $past(fn1_out[PIN_IRQ1]);
  endproperty
  a_irq_share: assert property (p_irq_share) // RL7
    else $error("Interrupt pin level not shared with port C.");

  property p_serial_kept;
    !first_q && !$past(sys_q[SYS_PORT_C_BIT])
      |-> fn1_in[PIN_CTS_A] == $past(pad_in[PIN_CTS_A]) && fn2_in[PIN_CTS_A] == IDLE_IN;
  endproperty
  a_serial_kept: assert property (p_serial_kept) // RL8
    else $error("Serial input not given to chan1.");

  property p_reset_map;
    first_q |-> sys_q == SYSTEM_SETUP_RST && psel_q == IRQ_PINSEL_RST
                ##1 pad_out[PIN_PA0] == $past(fn1_out[PIN_PA0]);
  endproperty
  a_reset_map: assert property (p_reset_map) // RL11
    else $error("Pins not on primary function after reset.");

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Register port did not answer after one wait cycle.");

  // Only the low byte is stored, so the upper lanes must read back as zero.
  property p_read_upper;
    !avs_waitrequest |-> avs_readdata[DATA_W-1:REG_W] == '0;
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("Register port returned data above the low byte.");
endmodule : pin_function_selector
`default_nettype wire

/* verif/pin_board_model.sv */
// Board-side model of the shared pins: resolves each pad from the selector's
// drive and enable, and otherwise shows the level that the board applies.
// Assumes one pad per bit, indexed as in pin_mux_pkg.
`timescale 1ns/10ps
`default_nettype none
module pin_board_model
  import pin_mux_pkg::*;
(
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] board_level,
  output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_in
);
  // An undriven pad shows the board level, never a held copy of the last
  // drive, so a wrong enable is seen at once.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : board_level[i];
    end
  end
endmodule : pin_board_model
`default_nettype wire

/* verif/multifunction_pin_selector_test.sv */
// Self-checking bench for the shared-pin selector and its register port.
// Assumes the board model resolves the pads and one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module multifunction_pin_selector_test;
  import pin_mux_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [ADDR_W-1:0]   avs_address = '0;
  logic [DATA_W-1:0]   avs_writedata = '0;
  logic [3:0]          avs_byteenable = 4'hf;
  logic [DATA_W-1:0]   avs_readdata;
  logic                avs_waitrequest;
  logic [NUM_PINS-1:0] pat = 28'h5a3c96e;
  logic [NUM_PINS-1:0] board_level = 28'h3c5a1b7;
  logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, fn1_in, fn2_in, fn3_in;
  int                  error_cnt = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  localparam logic [7:0] SYS_TAB [8] = '{8'h02, 8'h04, 8'h06, 8'h80, 8'h80, 8'h00, 8'h86, 8'hfd};
  localparam logic [7:0] PS_TAB  [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h08, 8'h08, 8'h04, 8'h0f};

  // Clock, and a cycle ceiling that cuts a hung bus wait short.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  pin_function_selector pin_function_selector_i (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .fn1_out(pat), .fn1_oe(pat), .fn1_in(fn1_in),
    .fn2_out(~pat), .fn2_oe(pat), .fn2_in(fn2_in), .fn3_out(pat), .fn3_oe(~pat),
    .fn3_in(fn3_in));

  pin_board_model pin_board_model_i (
    .pad_out(pad_out), .pad_oe(pad_oe), .board_level(board_level), .pad_in(pad_in));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [DATA_W-1:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'ha5c3e1, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [DATA_W-1:0] rd;
    bus(1'b0, a, 8'h00, 4'hf, rd);
    chk(what, rd, {24'h0, e});
  endtask : rd_chk

  // Which function owns a pin for given register values.
  function automatic logic [1:0] sel_of(input int p, input logic [7:0] s, input logic [7:0] r);
    if (p <= PIN_TRI2) return s[SYS_HOST_BIT] ? SEL_TER : (s[SYS_CHAN2_BIT] ? SEL_SEC : SEL_PRI);
    if (p <= PIN_CH2_6) return s[SYS_HOST_BIT] ? SEL_SEC : SEL_PRI;
    if (p == PIN_MWR) return !r[PS_STROBE_BIT] ? SEL_PRI : (s[SYS_PORT_C_BIT] ? SEL_SEC : SEL_TER);
    if (p <= PIN_SYNC_A) return s[SYS_PORT_C_BIT] ? SEL_SEC : SEL_PRI;
    if (p == PIN_DAISY) return r[PS_DAISY_BIT] ? SEL_SEC : SEL_PRI;
    if (p == PIN_MSTRB) return r[PS_STROBE_BIT] ? SEL_SEC : SEL_PRI;
    return SEL_PRI;
  endfunction : sel_of

  // Waits for the pins to settle, then checks every pin, the registers and port C.
  task automatic chk_pins(input logic [7:0] s, input logic [7:0] r);
    logic [NUM_PINS-1:0] eo, ee, lv, i1, i2, i3;
    logic [1:0]          k;
    logic [7:0]          ev;
    repeat (4) @(posedge clk);
    #1;
    for (int p = 0; p < NUM_PINS; p++) begin
      k = sel_of(p, s, r);
      eo[p] = (k == SEL_SEC) ? ~pat[p] : pat[p];
      ee[p] = (p == PIN_DAISY) ? r[PS_DAISY_BIT] : ((k == SEL_TER) ? ~pat[p] : pat[p]);
      lv[p] = ee[p] ? eo[p] : board_level[p];
      i1[p] = (k == SEL_PRI || p >= PIN_IRQ1) ? lv[p] : IDLE_IN;
      i2[p] = (k == SEL_SEC || p >= PIN_IRQ1) ? lv[p] : IDLE_IN;
      i3[p] = (k == SEL_TER || p >= PIN_IRQ1) ? lv[p] : IDLE_IN;
    end
    chk("pad_out", pad_out, eo);
    chk("pad_oe", pad_oe, ee);
    chk("fn1_in", fn1_in, i1);
    chk("fn2_in", fn2_in, i2);
    chk("fn3_in", fn3_in, i3);
    ev = {lv[PIN_IRQ2], lv[PIN_IRQ1], 6'h3f};
    if (s[SYS_PORT_C_BIT]) begin
      ev[5:0] = {lv[PIN_CHAN1_WAIT_REQ], lv[PIN_SYNC_A], lv[PIN_DTR_A], r[PS_STROBE_BIT] ? lv[PIN_MWR] : 1'b1,
                 lv[PIN_CTS_A], lv[PIN_DCD_A]};
    end
    rd_chk("port_c_view", OFS_PORT_C_VIEW, ev);
    rd_chk("system_setup_reg", OFS_SYSTEM_SETUP, s);
    rd_chk("irq_edge_pinsel_reg", OFS_IRQ_PINSEL, r);
  endtask : chk_pins

  task automatic t_mux_table;
    logic [DATA_W-1:0] rd;
    for (int pass = 0; pass < 2; pass++) begin
      pat <= pass ? 28'ha5c3691 : 28'h5a3c96e;
      board_level <= pass ? 28'hc3a5e48 : 28'h3c5a1b7;
      for (int i = 0; i < 8; i++) begin
        bus(1'b1, OFS_SYSTEM_SETUP, SYS_TAB[i], 4'hf, rd);
        bus(1'b1, OFS_IRQ_PINSEL, PS_TAB[i], 4'hf, rd);
        chk_pins(SYS_TAB[i], PS_TAB[i]);
      end
    end
    $display("test mux_table done");
  endtask : t_mux_table

  // Refused writes: unmapped place, read-only view, byte lane 0 off.
  task automatic t_bus_refusals;
    logic [DATA_W-1:0] rd;
    bus(1'b1, OFS_SYSTEM_SETUP, 8'h82, 4'hf, rd);
    bus(1'b1, OFS_IRQ_PINSEL, 8'h00, 4'hf, rd);
    bus(1'b1, 4'hc, 8'hff, 4'hf, rd);
    rd_chk("unmapped", 4'hc, 8'h00);
    bus(1'b1, OFS_PORT_C_VIEW, 8'h00, 4'hf, rd);
    bus(1'b1, OFS_SYSTEM_SETUP, 8'h04, 4'he, rd);
    chk_pins(8'h82, 8'h00);
    $display("test bus_refusals done");
  endtask : t_bus_refusals

  // A reset in mid-run puts every pin back on its primary function.
  task automatic t_reset_state(input logic mid);
    logic [DATA_W-1:0] rd;
    if (mid) begin
      bus(1'b1, OFS_SYSTEM_SETUP, 8'h86, 4'hf, rd);
      bus(1'b1, OFS_IRQ_PINSEL, 8'h0c, 4'hf, rd);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
    end
    chk_pins(SYSTEM_SETUP_RST, IRQ_PINSEL_RST);
    $display("test reset_state done");
  endtask : t_reset_state

  // Main sequence: 16 cycles of reset, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_state(1'b0);
    t_mux_table();
    t_bus_refusals();
    t_reset_state(1'b1);
    end_sim();
  end
endmodule : multifunction_pin_selector_test
`default_nettype wire
